// [dbs_port.sv]
// Device side of a burst-of-two DDR SRAM: capture, storage, read launch, echo clock.
// Assumes the host keeps loads two input-clock cycles apart and clocks stay running.
`timescale 1ns/1ps
module dbs_port
	import dbs_pkg::*;
(
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic k_clk_in,
	input wire logic c_clk_in,
	input wire logic single_clk_mode_in,
	input wire logic dll_disable_n_in,
	input wire logic load_strobe_n_in,
	input wire logic rw_in,
	input wire logic [dbs_pkg::ADDR_W-1:0] addr_in,
	input wire logic [dbs_pkg::LANES-1:0] byte_write_select_n_in,
	input wire logic [dbs_pkg::DATA_W-1:0] dq_in,
	output logic [dbs_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_out,
	output logic echo_clock_out,
	output logic echo_clock_n_out,
	output logic [dbs_pkg::CNT_W-1:0] read_count_out,
	output logic [dbs_pkg::CNT_W-1:0] write_count_out
);
	import dbs_pkg::*;

	// ----------------------------------------
	// Reset synchronisers and strap
	// ----------------------------------------
	logic k_rst_sync1;
	logic k_rst_n;
	logic o_rst_sync1;
	logic o_rst_n;
	logic dll_sync1;
	logic dll_on;
	logic out_clk;

	always_ff @(posedge k_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			k_rst_sync1 <= 1'b0;
			k_rst_n <= 1'b0;
		end
		else
		begin
			k_rst_sync1 <= 1'b1;
			k_rst_n <= k_rst_sync1;
		end
	end

	always_ff @(posedge out_clk or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			o_rst_sync1 <= 1'b0;
			o_rst_n <= 1'b0;
		end
		else
		begin
			o_rst_sync1 <= 1'b1;
			o_rst_n <= o_rst_sync1;
		end
	end

	always_ff @(posedge k_clk_in or negedge k_rst_n)
	begin
		if (!k_rst_n)
		begin
			dll_sync1 <= 1'b0;
			dll_on <= 1'b0;
		end
		else
		begin
			dll_sync1 <= dll_disable_n_in;
			dll_on <= dll_sync1;
		end
	end

	// Single mode falls back to K; the strap is static
	assign out_clk = single_clk_mode_in ? k_clk_in : c_clk_in;
	assign echo_clock_out = out_clk;
	assign echo_clock_n_out = ~out_clk;

	// ----------------------------------------
	// Command capture on rising K
	// ----------------------------------------
	logic burst_lsb_address;
	logic load_rd;
	logic load_wr;
	logic wr_pend;
	logic wr_hi;
	logic wr_commit;
	logic rd_pend;
	logic rd_pend_d;
	logic [ADDR_W-1:0] wr_addr;
	logic [ROW_W-1:0] wr_row;
	logic [DATA_W-1:0] hi_data;
	logic [LANES-1:0] hi_bws;
	logic [DATA_W-1:0] rd_word [BURST_LEN];
	logic [DATA_W-1:0] fetch [BURST_LEN];
	logic [DATA_W-1:0] mem [2][ARR_DEPTH];

	assign burst_lsb_address = addr_in[0];
	assign wr_row = wr_addr[ADDR_W-1:1];
	assign load_rd = !load_strobe_n_in && rw_in;
	assign load_wr = !load_strobe_n_in && !rw_in;

	// Byte-lane merge: deselected lanes keep the old contents
	function automatic logic [DATA_W-1:0] dbs_merge(input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w, input logic [LANES-1:0] sel_n);
		logic [DATA_W-1:0] res;
		res = old_w;
		for (int i = 0; i < LANES; i++)
		begin
			if (!sel_n[i])
			begin
				res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction

	// Back-to-back loads are not guarded against
	always_ff @(posedge k_clk_in or negedge k_rst_n)
	begin
		if (!k_rst_n)
		begin
			wr_pend <= 1'b0;
			wr_hi <= 1'b0;
			wr_commit <= 1'b0;
			rd_pend <= 1'b0;
			rd_pend_d <= 1'b0;
			wr_addr <= ADDR_RST;
		end
		else
		begin
			wr_pend <= load_wr;
			wr_hi <= wr_pend;
			wr_commit <= wr_hi;
			rd_pend <= load_rd;
			rd_pend_d <= rd_pend;
			if (load_wr)
			begin
				wr_addr <= addr_in;
			end
		end
	end

	// Its selects on the same edge
	always_ff @(negedge k_clk_in or negedge k_rst_n)
	begin
		if (!k_rst_n)
		begin
			hi_data <= DATA_RST;
			hi_bws <= BWS_RST;
		end
		else if (wr_hi)
		begin
			hi_data <= dq_in;
			hi_bws <= byte_write_select_n_in;
		end
	end

	// ----------------------------------------
	// Storage: two arrays, one per burst lsb
	// ----------------------------------------
	// Two arrays of 1M x 36
	// Beat one to the loaded lsb, beat two to the toggled lsb
	always_ff @(posedge k_clk_in)
	begin
		if (wr_pend)
		begin
			mem[wr_addr[0]][wr_row] <= dbs_merge(mem[wr_addr[0]][wr_row], dq_in, byte_write_select_n_in);
		end
		// Second beat lands at T0+2, before a write loaded then can move wr_addr
		if (wr_hi)
		begin
			mem[~wr_addr[0]][wr_row] <= dbs_merge(mem[~wr_addr[0]][wr_row], hi_data, hi_bws);
		end
	end

	// Burst counter: word b sits in array lsb xor b
	for (genvar b = 0; b < BURST_LEN; b++)
	begin : g_fetch
		logic arr;
		assign arr = burst_lsb_address ^ 1'(b);
		// Forward a second write beat committing on this same edge
		always_comb
		begin
			fetch[b] = mem[arr][addr_in[ADDR_W-1:1]];
			if (wr_hi && (addr_in[ADDR_W-1:1] == wr_row) && (arr == ~wr_addr[0]))
			begin
				fetch[b] = dbs_merge(fetch[b], hi_data, hi_bws);
			end
		end
		always_ff @(posedge k_clk_in or negedge k_rst_n)
		begin
			if (!k_rst_n)
			begin
				rd_word[b] <= DATA_RST;
			end
			else if (load_rd)
			begin
				rd_word[b] <= fetch[b];
			end
		end
	end

	// ----------------------------------------
	// Read launch on the output clock pair
	// ----------------------------------------
	logic [DATA_W-1:0] q_pos;
	logic [DATA_W-1:0] q_neg;
	logic oe_pos;
	logic oe_neg;

	// Loop off: word one at +1; loop on: word one at +1.5
	always_ff @(posedge out_clk or negedge o_rst_n)
	begin
		if (!o_rst_n)
		begin
			q_pos <= DATA_RST;
			oe_pos <= 1'b0;
		end
		else
		begin
			oe_pos <= dll_on ? rd_pend_d : rd_pend;
			q_pos <= dll_on ? rd_word[1] : rd_word[0];
		end
	end

	always_ff @(negedge out_clk or negedge o_rst_n)
	begin
		if (!o_rst_n)
		begin
			q_neg <= DATA_RST;
			oe_neg <= 1'b0;
		end
		else
		begin
			oe_neg <= rd_pend_d;
			q_neg <= dll_on ? rd_word[0] : rd_word[1];
		end
	end

	assign dq_out = out_clk ? q_pos : q_neg;
	assign dq_oe_out = out_clk ? oe_pos : oe_neg;

	// ----------------------------------------
	// Activity counters into the clk_in domain
	// ----------------------------------------
	logic [CNT_W-1:0] evt_bin [EVT_N];
	logic [CNT_W-1:0] evt_gray [EVT_N];
	logic [CNT_W-1:0] evt_s1 [EVT_N];
	logic [CNT_W-1:0] evt_s2 [EVT_N];
	logic [CNT_W-1:0] evt_cnt [EVT_N];
	logic evt_hit [EVT_N];

	assign evt_hit[EVT_READ] = load_rd;
	assign evt_hit[EVT_WRITE] = load_wr;

	for (genvar e = 0; e < EVT_N; e++)
	begin : g_evt
		logic [CNT_W-1:0] next_bin;
		logic [CNT_W-1:0] s2_bin;
		assign next_bin = evt_bin[e] + CNT_W'(1);
		always_ff @(posedge k_clk_in or negedge k_rst_n)
		begin
			if (!k_rst_n)
			begin
				evt_bin[e] <= CNT_RST;
				evt_gray[e] <= CNT_RST;
			end
			else if (evt_hit[e])
			begin
				evt_bin[e] <= next_bin;
				evt_gray[e] <= next_bin ^ (next_bin >> 1);
			end
		end
		always_comb
		begin
			s2_bin = evt_s2[e];
			for (int i = CNT_W - 2; i >= 0; i--)
			begin
				s2_bin[i] = s2_bin[i+1] ^ evt_s2[e][i];
			end
		end
		always_ff @(posedge clk_in or negedge nrst_in)
		begin
			if (!nrst_in)
			begin
				evt_s1[e] <= CNT_RST;
				evt_s2[e] <= CNT_RST;
				evt_cnt[e] <= CNT_RST;
			end
			else
			begin
				evt_s1[e] <= evt_gray[e];
				evt_s2[e] <= evt_s1[e];
				evt_cnt[e] <= s2_bin;
			end
		end
	end

	assign read_count_out = evt_cnt[EVT_READ];
	assign write_count_out = evt_cnt[EVT_WRITE];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_rd_load;
		!load_strobe_n_in && rw_in;
	endsequence
	sequence s_wr_load;
		!load_strobe_n_in && !rw_in;
	endsequence

	a_read_decode: assert property (@(posedge k_clk_in) disable iff (!k_rst_n)
		s_rd_load |=> rd_pend && !wr_pend)
		else $error("read load did not start a read");
	a_write_decode: assert property (@(posedge k_clk_in) disable iff (!k_rst_n)
		s_wr_load |=> wr_pend && !rd_pend && wr_addr == $past(addr_in))
		else $error("write load did not start a write");
	a_no_strobe_idle: assert property (@(posedge k_clk_in) disable iff (!k_rst_n)
		load_strobe_n_in |=> !rd_pend && !wr_pend)
		else $error("access started without load strobe");
	a_write_burst_seq: assert property (@(posedge k_clk_in) disable iff (!k_rst_n)
		s_wr_load |=> wr_pend ##1 wr_hi && !wr_pend ##1 wr_commit && !wr_hi)
		else $error("write burst not two beats");
	a_lane_zero_write: assert property (@(posedge k_clk_in) disable iff (!k_rst_n)
		wr_pend && !byte_write_select_n_in[0] |=> mem[wr_addr[0]][wr_row][8:0] == $past(dq_in[8:0]))
		else $error("lane zero not written");
	a_byte_keep_all: assert property (@(posedge k_clk_in) disable iff (!k_rst_n)
		wr_hi && hi_bws == 4'hF |=> mem[$past(~wr_addr[0])][$past(wr_row)] == $past(mem[~wr_addr[0]][wr_row]))
		else $error("deselected bytes changed");
	a_rd_off_window: assert property (@(posedge out_clk) disable iff (!o_rst_n)
		rd_pend && !dll_on |=> oe_pos ##1 !oe_pos)
		else $error("loop-off read window wrong");
	a_rd_on_window: assert property (@(posedge out_clk) disable iff (!o_rst_n)
		rd_pend && dll_on |=> !oe_pos ##1 oe_pos && q_pos == rd_word[1])
		else $error("loop-on read window wrong");
	a_float_idle: assert property (@(negedge out_clk) disable iff (!o_rst_n)
		!rd_pend_d |=> !oe_neg)
		else $error("output driven outside read");
	a_echo_pair: assert property (@(posedge clk_in) disable iff (!nrst_in)
		echo_clock_out != echo_clock_n_out)
		else $error("echo pair not complementary");
endmodule

// [dbs_pkg.sv]
// Constants for the burst-of-two double-data-rate SRAM port.
// Assumes the 36-bit data configuration; the 18-bit build would use 22 address bits.
package dbs_pkg;
	// ----------------------------------------
	// Array geometry
	// ----------------------------------------
	localparam int DATA_W = 36;
	localparam int ADDR_W = 21;
	localparam int ADDR_W_X18 = 22;
	localparam int LANE_W = 9;
	localparam int LANES = 4;
	localparam int ROW_W = ADDR_W - 1;
	localparam int ARR_DEPTH = 1 << ROW_W;
	localparam int BURST_LEN = 2;
	// ----------------------------------------
	// Activity counters and reset values
	// ----------------------------------------
	localparam int CNT_W = 8;
	localparam int EVT_N = 2;
	localparam int EVT_READ = 0;
	localparam int EVT_WRITE = 1;
	localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 21'h00_0000;
	localparam logic [LANES-1:0] BWS_RST = 4'hF;
	localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
endpackage

// [dbs_host.sv]
// Host controller model for the burst-of-two SRAM port: free-running K clock, C clock gated by c_run_in, and load cycles.
// Assumes the bench calls cmd no faster than one load every two link clock cycles.
`timescale 1ns/1ps
module dbs_host
	import dbs_pkg::*;
(
	input wire logic c_run_in,
	output logic k_clk_out,
	output logic c_clk_out,
	output logic load_strobe_n_out,
	output logic rw_out,
	output logic [dbs_pkg::ADDR_W-1:0] addr_out,
	output logic [dbs_pkg::LANES-1:0] byte_write_select_n_out,
	output logic [dbs_pkg::DATA_W-1:0] dq_out
);
	// Output clock is stopped in single clock mode
	assign c_clk_out = c_run_in & k_clk_out;
	initial
	begin
		k_clk_out = 1'b0;
		forever #3 k_clk_out = ~k_clk_out;
	end
	initial
	begin
		load_strobe_n_out = 1'b1;
		rw_out = 1'b1;
		addr_out = '0;
		byte_write_select_n_out = 4'hF;
		dq_out = '0;
	end
	// cmd itself waits one idle edge before asserting the load
	// Beat one stands at the rising edge after the load, beat two at the falling edge after that
	task automatic cmd(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1,
		input logic [LANES-1:0] b0, b1);
		@(posedge k_clk_out);
		load_strobe_n_out <= 1'b0;
		rw_out <= !w;
		addr_out <= a;
		@(posedge k_clk_out);
		load_strobe_n_out <= 1'b1;
		rw_out <= w;
		addr_out <= ~a;
		dq_out <= w ? d0 : ~dq_out;
		byte_write_select_n_out <= w ? b0 : ~byte_write_select_n_out;
		@(posedge k_clk_out);
		dq_out <= w ? d1 : ~dq_out;
		byte_write_select_n_out <= w ? b1 : ~byte_write_select_n_out;
	endtask
	// Busy-looking pins with the load strobe left high
	task automatic idle(input int n);
		repeat (n)
		begin
			@(posedge k_clk_out);
			rw_out <= ~rw_out;
			addr_out <= ~addr_out;
			dq_out <= ~dq_out;
			byte_write_select_n_out <= ~byte_write_select_n_out;
		end
	endtask
endmodule

// [ddr_burst2_sram_port_tb.sv]
// Self-checking bench for dbs_port driven by the dbs_host model.
// Assumes the output clock is phase aligned to the input clock.
`timescale 1ns/1ps
module ddr_burst2_sram_port_tb;
	import dbs_pkg::*;
	logic clk_in, nrst_in, dll_n, single, c_run, k, c, ld_n, rw, dll;
	logic [ADDR_W-1:0] addr;
	logic [LANES-1:0] byte_write_select_n;
	logic [DATA_W-1:0] h_dq, dq_out, dq_wire;
	logic dq_oe_out, echo_clock_out, echo_clock_n_out;
	logic [CNT_W-1:0] rc, wc, nr, nw;
	int n_mismatch, comparisons;
	logic [DATA_W-1:0] m [logic [ADDR_W-1:0]];
	assign dq_wire = dq_oe_out ? dq_out : h_dq;
	dbs_host host (.c_run_in(c_run), .k_clk_out(k), .c_clk_out(c), .load_strobe_n_out(ld_n), .rw_out(rw),
		.addr_out(addr), .byte_write_select_n_out(byte_write_select_n), .dq_out(h_dq));
	dbs_port DUT (.clk_in(clk_in), .nrst_in(nrst_in), .k_clk_in(k), .c_clk_in(c), .single_clk_mode_in(single),
		.dll_disable_n_in(dll_n), .load_strobe_n_in(ld_n), .rw_in(rw), .addr_in(addr),
		.byte_write_select_n_in(byte_write_select_n), .dq_in(dq_wire), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
		.echo_clock_out(echo_clock_out), .echo_clock_n_out(echo_clock_n_out),
		.read_count_out(rc), .write_count_out(wc));
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	task automatic print_verdict;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#20000;
		n_mismatch++;
		print_verdict();
	end
	task automatic chk(input logic [DATA_W-1:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [DATA_W-1:0] mrg(input logic [DATA_W-1:0] o, n, input logic [LANES-1:0] s);
		mrg = o;
		for (int i = 0; i < LANES; i++)
			if (!s[i])
				mrg[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
	endfunction
	// ----------------------------------------
	// Scenario tasks
	// ----------------------------------------
	task automatic rst(input logic d, s);
		@(posedge clk_in);
		nrst_in <= 1'b0;
		dll_n <= d;
		single <= s;
		c_run <= !s;
		dll = d;
		nr = '0;
		nw = '0;
		repeat (8) @(posedge clk_in);
		chk(dq_oe_out, 1'b0);
		nrst_in <= 1'b1;
		repeat (3) @(posedge k);
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d0, d1, input logic [LANES-1:0] b0, b1);
		host.cmd(1'b1, a, d0, d1, b0, b1);
		m[a] = mrg(m[a], d0, b0);
		m[a ^ 21'h1] = mrg(m[a ^ 21'h1], d1, b1);
		nw++;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		host.cmd(1'b0, a, '0, '0, 4'hF, 4'hF);
		nr++;
		#1.5;
		if (dll)
		begin
			chk(dq_oe_out, 1'b0);
			#3;
		end
		chk(dq_oe_out, 1'b1);
		chk(dq_out, m[a]);
		#3;
		chk(dq_oe_out, 1'b1);
		chk(dq_out, m[a ^ 21'h1]);
		#3;
		chk(dq_oe_out, 1'b0);
	endtask
	task automatic echo;
		@(posedge k);
		#1.5;
		chk(echo_clock_out, 1'b1);
		chk(echo_clock_n_out, 1'b0);
		#3;
		chk(echo_clock_out, 1'b0);
		chk(echo_clock_n_out, 1'b1);
	endtask
	task automatic cnt;
		repeat (6) @(posedge clk_in);
		chk(rc, nr);
		chk(wc, nw);
	endtask
	task automatic lanes;
		for (int i = 0; i < LANES; i++)
		begin
			wr(21'h00_1234, 36'hF_FFFF_FFFF, 36'h0_0000_0000, ~(4'h1 << i), 4'h1 << i);
			rd(21'h00_1234);
		end
	endtask
	task automatic quiet;
		fork
			host.idle(8);
			begin
				#1.5;
				repeat (16)
				begin
					chk(dq_oe_out, 1'b0);
					#3;
				end
			end
		join
		rd(21'h00_1234);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		nrst_in = 1'b0;
		dll_n = 1'b0;
		single = 1'b0;
		c_run = 1'b1;
		dll = 1'b0;
		n_mismatch = 0;
		comparisons = 0;
		rst(1'b0, 1'b0);
		echo();
		wr(21'h00_1234, 36'h1_2345_6789, 36'hA_BCDE_F012, 4'h0, 4'h0);
		rd(21'h00_1234);
		wr(21'h00_0101, 36'h5_5555_AAAA, 36'h3_3333_CCCC, 4'h0, 4'h0);
		rd(21'h00_0100);
		lanes();
		quiet();
		wr(21'h1F_FFFE, 36'h9_8765_4321, 36'h0_F0F0_F0F0, 4'h0, 4'h0);
		rd(21'h1F_FFFE);
		cnt();
		rst(1'b1, 1'b0);
		rd(21'h00_0100);
		cnt();
		rst(1'b0, 1'b1);
		echo();
		rd(21'h00_1234);
		cnt();
		print_verdict();
	end
endmodule
